// [core/sat_top.sv]
// sat_top: segment translation core with user and system segment state
// assumes pipeline holds no load while seg_busy_o is high
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
module sat_top
  import sat_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [6:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic seg_load_i,
  input wire logic seg_far_i,
  input wire logic [2:0] seg_idx_i,
  input wire logic [15:0] seg_sel_i,
  output logic seg_busy_o,
  input wire logic vec_event_i,
  input wire logic [7:0] vec_num_i,
  output logic gate_valid_o,
  output logic [31:0] gate_addr_o,
  input wire logic xlat_req_i,
  input wire logic [2:0] xlat_seg_i,
  input wire logic [63:0] xlat_ea_i,
  output logic lin_valid_o,
  output logic [63:0] lin_addr_o,
  output logic lin_fault_o,
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [63:0] mem_data_i,
  input wire logic [7:0] mem_attr_i,
  output logic [2:0] mode_o,
  output logic [1:0] cpl_o,
  output logic opsize32_o,
  output logic code64_o
);
  sat_mode_e mode_q;
  logic [15:0] sel_q [NSEG];
  logic [31:0] base_q [NSEG];
  logic [31:0] limit_q [NSEG];
  logic [7:0] attr_q [NSEG];
  logic [31:0] gtb_q, gtl_q, ltb_q, ltl_q, itb_q, itl_q, tkb_q, tkl_q;
  logic busy_q;
  logic [2:0] pend_idx_q;
  logic [15:0] pend_sel_q;
  logic [31:0] rd_d;
  logic real_ish;
  logic long_ish;
  logic ld;
  logic [2:0] ld_idx;
  logic wr_ctrl;
  logic cs_done;
  logic [2:0] xs;

  sat_desc_if dif ();

  assign real_ish = (mode_q == SAT_REAL) || (mode_q == SAT_V86);
  assign long_ish = (mode_q == SAT_COMPAT) || (mode_q == SAT_LONG);
  // loads arriving while a fetch is out are dropped; busy tells the pipe
  assign ld = (seg_load_i || seg_far_i) && !busy_q;
  assign ld_idx = seg_far_i ? SEG_CS : seg_idx_i;
  assign wr_ctrl = wr_i && (addr_i == OFS_CTRL);
  assign cs_done = dif.done && (pend_idx_q == SEG_CS);

  // no table walk while real or v86
  assign dif.start = ld && !real_ish;
  assign dif.addr = tbl_entry(seg_sel_i[SEL_TI] ? ltb_q : gtb_q,
                              seg_sel_i[15:SEL_IDX_LO]);

  sat_desc_fetch u_fetch (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .dif(dif),
    .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o),
    .mem_ack_i(mem_ack_i),
    .mem_data_i(mem_data_i),
    .mem_attr_i(mem_attr_i)
  );

  // mode sequencing
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_q <= SAT_REAL;
    end else if (mode_q == SAT_V86 && vec_event_i) begin
      mode_q <= SAT_PROT;
    end else if (cs_done && long_ish) begin
      mode_q <= lm_mode(dif.attr);
    end else if (wr_ctrl) begin
      unique case (mode_q)
        SAT_REAL: begin
          if (wdata_i[1:0] == REQ_PROT) begin
            mode_q <= SAT_PROT;
          end
        end
        SAT_PROT: begin
          if (wdata_i[1:0] == REQ_REAL) begin
            mode_q <= SAT_REAL;
          end else if (wdata_i[1:0] == REQ_V86) begin
            mode_q <= SAT_V86;
          end else if (wdata_i[1:0] == REQ_LONG) begin
            mode_q <= lm_mode(attr_q[SEG_CS]);
          end
        end
        SAT_COMPAT, SAT_LONG: begin
          if (wdata_i[1:0] == REQ_PROT) begin
            mode_q <= SAT_PROT;
          end
        end
        SAT_V86: begin
          // v86 leaves only through an interrupt or exception
          mode_q <= SAT_V86;
        end
        default: begin
          mode_q <= SAT_REAL;
        end
      endcase
    end
  end

  // fetch bookkeeping
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      busy_q <= 1'b0;
      pend_idx_q <= SEG_ES;
      pend_sel_q <= 16'h0000;
    end else if (dif.start) begin
      busy_q <= 1'b1;
      pend_idx_q <= ld_idx;
      pend_sel_q <= seg_sel_i;
    end else if (dif.done) begin
      busy_q <= 1'b0;
    end
  end

  // visible selectors and hidden records
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < NSEG; i++) begin
        sel_q[i] <= 16'h0000;
        base_q[i] <= 32'h00000000;
        limit_q[i] <= RST_LIMIT;
        attr_q[i] <= RST_ATTR;
      end
    end else if (dif.done) begin
      sel_q[pend_idx_q] <= pend_sel_q;
      base_q[pend_idx_q] <= dif.data[31:0];
      limit_q[pend_idx_q] <= dif.data[DESC_LIMIT_LO +: 32];
      attr_q[pend_idx_q] <= dif.attr;
    end else if (ld && real_ish) begin
      // limit and attributes stay as they were
      sel_q[ld_idx] <= seg_sel_i;
      base_q[ld_idx] <= real_base(seg_sel_i);
    end else if (wr_i && addr_i == OFS_AUX1) begin
      base_q[SEG_FS] <= wdata_i;
    end else if (wr_i && addr_i == OFS_AUX2) begin
      base_q[SEG_GS] <= wdata_i;
    end
  end

  // system segment registers, writable in any mode
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      gtb_q <= 32'h00000000;
      gtl_q <= RST_TBL_LIMIT;
      ltb_q <= 32'h00000000;
      ltl_q <= RST_TBL_LIMIT;
      itb_q <= 32'h00000000;
      itl_q <= RST_TBL_LIMIT;
      tkb_q <= 32'h00000000;
      tkl_q <= RST_TBL_LIMIT;
    end else if (wr_i) begin
      unique case (addr_i)
        OFS_GTB: gtb_q <= wdata_i;
        OFS_GTL: gtl_q <= wdata_i;
        OFS_LTB: ltb_q <= wdata_i;
        OFS_LTL: ltl_q <= wdata_i;
        OFS_ITB: itb_q <= wdata_i;
        OFS_ITL: itl_q <= wdata_i;
        OFS_TKB: tkb_q <= wdata_i;
        OFS_TKL: tkl_q <= wdata_i;
        default: begin
        end
      endcase
    end
  end

  // interrupt gate address, eight-byte entries
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      gate_valid_o <= 1'b0;
      gate_addr_o <= 32'h00000000;
    end else begin
      gate_valid_o <= vec_event_i;
      if (vec_event_i) begin
        gate_addr_o <= tbl_entry(itb_q, {5'h00, vec_num_i});
      end
    end
  end

  // register read mux
  always_comb begin
    rd_d = 32'h00000000;
    unique case (addr_i)
      OFS_CTRL: rd_d = {29'h0, mode_q};
      OFS_STAT: rd_d = {29'h0, busy_q, attr_q[SEG_CS][1:0]};
      OFS_GTB: rd_d = gtb_q;
      OFS_GTL: rd_d = gtl_q;
      OFS_LTB: rd_d = ltb_q;
      OFS_LTL: rd_d = ltl_q;
      OFS_ITB: rd_d = itb_q;
      OFS_ITL: rd_d = itl_q;
      OFS_TKB: rd_d = tkb_q;
      OFS_TKL: rd_d = tkl_q;
      OFS_AUX1: rd_d = base_q[SEG_FS];
      OFS_AUX2: rd_d = base_q[SEG_GS];
      default: begin
        for (int i = 0; i < NSEG; i++) begin
          if (addr_i == OFS_SEL0 + 7'(4 * i)) begin
            rd_d = {16'h0000, sel_q[i]};
          end
          if (addr_i == OFS_BASE0 + 7'(4 * i)) begin
            rd_d = base_q[i];
          end
        end
      end
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= rd_i ? rd_d : 32'h00000000;
    end
  end

  // mode, code segment attributes and load busy seen by the pipeline
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_o <= SAT_REAL;
      cpl_o <= 2'h0;
      opsize32_o <= 1'b0;
      code64_o <= 1'b0;
      seg_busy_o <= 1'b0;
    end else begin
      mode_o <= mode_q;
      cpl_o <= attr_q[SEG_CS][1:0];
      opsize32_o <= attr_q[SEG_CS][ATTR_D];
      code64_o <= (mode_q == SAT_LONG);
      seg_busy_o <= dif.start || (busy_q && !dif.done);
    end
  end

  // unknown slots fall back to the default data segment
  assign xs = (xlat_seg_i > SEG_GS) ? SEG_DS : xlat_seg_i;

  sat_addr_calc u_calc (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .req_i(xlat_req_i),
    .mode_i(mode_q),
    .aux_i(xs == SEG_FS || xs == SEG_GS),
    .base_i(base_q[xs]),
    .limit_i(limit_q[xs]),
    .ea_i(xlat_ea_i),
    .valid_o(lin_valid_o),
    .addr_o(lin_addr_o),
    .fault_o(lin_fault_o)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_real_load;
    ld && real_ish && !dif.done;
  endsequence
  sequence s_fetch_out;
    dif.start ##1 mem_req_o;
  endsequence

  chk_reset_real: assert property ($fell(reset_i) |-> mode_q == SAT_REAL)
    else $error("not in real mode after reset");
  chk_leave_real: assert property (
    $past(mode_q) == SAT_REAL && mode_q != SAT_REAL |-> mode_q == SAT_PROT)
    else $error("left real mode to other than protected");
  chk_real_base: assert property (
    s_real_load |=> base_q[$past(ld_idx)] == real_base($past(seg_sel_i))
      && limit_q[$past(ld_idx)] == $past(limit_q[ld_idx]))
    else $error("real load base or limit wrong");
  chk_far_cs: assert property (
    s_real_load and seg_far_i |=> sel_q[SEG_CS] == $past(seg_sel_i))
    else $error("far transfer missed code selector");
  chk_no_tables: assert property (real_ish && !busy_q |=> !mem_req_o)
    else $error("table fetch in real mode");
  chk_cs_long: assert property (
    cs_done && long_ish |=> mode_q == lm_mode($past(dif.attr)))
    else $error("code fetch did not set long mode");
  chk_v86_event: assert property (
    mode_q == SAT_V86 && vec_event_i |=> mode_q == SAT_PROT)
    else $error("v86 event did not enter protected");
  chk_desc_addr: assert property (
    s_fetch_out |-> mem_addr_o == $past(seg_sel_i[SEL_TI] ? ltb_q : gtb_q)
      + {16'h0000, $past(seg_sel_i[15:3]), 3'h0})
    else $error("descriptor address wrong");
  chk_hidden_fill: assert property (
    dif.done |=> base_q[$past(pend_idx_q)] == $past(dif.data[31:0])
      && sel_q[$past(pend_idx_q)] == $past(pend_sel_q))
    else $error("hidden record not filled");
  chk_gate_addr: assert property (
    vec_event_i |=> gate_valid_o ##0 gate_addr_o == $past(itb_q)
      + {21'h0, $past(vec_num_i), 3'h0})
    else $error("gate address wrong");
endmodule // sat_top
`default_nettype wire

// [common/sat_pkg.sv]
// sat_pkg: constants, mode type and helpers of the segment translation core
// assumes one core clock and a word-wide register port
package sat_pkg;

  localparam int unsigned NSEG = 6;

  // user segment slots, in instruction-encoding order
  localparam logic [2:0] SEG_ES = 3'h0;
  localparam logic [2:0] SEG_CS = 3'h1;
  localparam logic [2:0] SEG_SS = 3'h2;
  localparam logic [2:0] SEG_DS = 3'h3;
  localparam logic [2:0] SEG_FS = 3'h4;
  localparam logic [2:0] SEG_GS = 3'h5;

  // register byte offsets
  localparam logic [6:0] OFS_CTRL = 7'h00;
  localparam logic [6:0] OFS_STAT = 7'h04;
  localparam logic [6:0] OFS_GTB = 7'h08;
  localparam logic [6:0] OFS_GTL = 7'h0c;
  localparam logic [6:0] OFS_LTB = 7'h10;
  localparam logic [6:0] OFS_LTL = 7'h14;
  localparam logic [6:0] OFS_ITB = 7'h18;
  localparam logic [6:0] OFS_ITL = 7'h1c;
  localparam logic [6:0] OFS_TKB = 7'h20;
  localparam logic [6:0] OFS_TKL = 7'h24;
  localparam logic [6:0] OFS_AUX1 = 7'h28;
  localparam logic [6:0] OFS_AUX2 = 7'h2c;
  localparam logic [6:0] OFS_SEL0 = 7'h30;
  localparam logic [6:0] OFS_BASE0 = 7'h48;

  // mode request codes in the control register
  localparam logic [1:0] REQ_REAL = 2'h0;
  localparam logic [1:0] REQ_PROT = 2'h1;
  localparam logic [1:0] REQ_V86 = 2'h2;
  localparam logic [1:0] REQ_LONG = 2'h3;

  // reset values: 64K limit, read/write data attributes
  localparam logic [31:0] RST_LIMIT = 32'h0000ffff;
  localparam logic [7:0] RST_ATTR = 8'h10;
  localparam logic [31:0] RST_TBL_LIMIT = 32'h0000ffff;

  // field positions
  localparam int unsigned ATTR_D = 2;
  localparam int unsigned ATTR_L = 3;
  localparam int unsigned SEL_TI = 2;
  localparam int unsigned SEL_IDX_LO = 3;
  localparam int unsigned DESC_LIMIT_LO = 32;
  localparam int unsigned REAL_ADDR_W = 20;

  typedef enum logic [2:0] {
    SAT_REAL = 3'b000,
    SAT_PROT = 3'b001,
    SAT_COMPAT = 3'b011,
    SAT_LONG = 3'b010,
    SAT_V86 = 3'b110
  } sat_mode_e;

  function automatic logic [31:0] real_base(input logic [15:0] sel);
    real_base = {12'h000, sel, 4'h0};
  endfunction

  // eight-byte entries, so index scaled by 8
  function automatic logic [31:0] tbl_entry(input logic [31:0] base, input logic [12:0] idx);
    tbl_entry = base + {16'h0000, idx, 3'h0};
  endfunction

  function automatic sat_mode_e lm_mode(input logic [7:0] cs_attr);
    lm_mode = cs_attr[ATTR_L] ? SAT_LONG : SAT_COMPAT;
  endfunction

endpackage

// [common/sat_desc_if.sv]
// sat_desc_if: descriptor fetch request and answer inside the core
// assumes start is a one-cycle pulse, done answers it once
`timescale 1ns/1ns
`default_nettype none
interface sat_desc_if;
  logic start;
  logic [31:0] addr;
  logic done;
  logic [63:0] data;
  logic [7:0] attr;
  modport req (output start, output addr, input done, input data, input attr);
  modport rsp (input start, input addr, output done, output data, output attr);
endinterface
`default_nettype wire

// [core/sat_desc_fetch.sv]
// sat_desc_fetch: reads one descriptor from memory per start pulse
// assumes memory answers each req, held here until then, with one ack
`timescale 1ns/1ns
`default_nettype none
module sat_desc_fetch (
  input wire logic clk_i,
  input wire logic reset_i,
  sat_desc_if.rsp dif,
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [63:0] mem_data_i,
  input wire logic [7:0] mem_attr_i
);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mem_req_o <= 1'b0;
      mem_addr_o <= 32'h00000000;
    end else if (dif.start && !mem_req_o) begin
      mem_req_o <= 1'b1;
      mem_addr_o <= dif.addr;
    end else if (mem_ack_i) begin
      mem_req_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dif.done <= 1'b0;
      dif.data <= 64'h0;
      dif.attr <= 8'h00;
    end else begin
      dif.done <= mem_req_o && mem_ack_i;
      if (mem_req_o && mem_ack_i) begin
        dif.data <= mem_data_i;
        dif.attr <= mem_attr_i;
      end
    end
  end
endmodule // sat_desc_fetch
`default_nettype wire

// [core/sat_addr_calc.sv]
// sat_addr_calc: forms a linear address from a segment record and mode
// assumes the record is stable in the cycle of the request
`timescale 1ns/1ns
`default_nettype none
module sat_addr_calc
  import sat_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req_i,
  input wire sat_mode_e mode_i,
  input wire logic aux_i,
  input wire logic [31:0] base_i,
  input wire logic [31:0] limit_i,
  input wire logic [63:0] ea_i,
  output logic valid_o,
  output logic [63:0] addr_o,
  output logic fault_o
);
  logic [63:0] addr_d;
  logic fault_d;
  logic [REAL_ADDR_W-1:0] real_sum;
  logic [31:0] prot_sum;

  // wrap at 1MB, as the 20-bit bus would
  assign real_sum = REAL_ADDR_W'(base_i + {16'h0000, ea_i[15:0]});
  assign prot_sum = base_i + ea_i[31:0];

  always_comb begin
    addr_d = 64'h0;
    fault_d = 1'b0;
    unique case (mode_i)
      SAT_REAL, SAT_V86: begin
        addr_d = {44'h0, real_sum};
        fault_d = {16'h0000, ea_i[15:0]} > limit_i;
      end
      SAT_PROT, SAT_COMPAT: begin
        addr_d = {32'h0, prot_sum};
        fault_d = (ea_i[63:32] != 32'h0) || (ea_i[31:0] > limit_i);
      end
      SAT_LONG: begin
        // only the two aux segments keep a base; no limit check
        addr_d = aux_i ? ea_i + {32'h0, base_i} : ea_i;
      end
      default: begin
        fault_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      valid_o <= 1'b0;
      addr_o <= 64'h0;
      fault_o <= 1'b0;
    end else begin
      valid_o <= req_i;
      addr_o <= addr_d;
      fault_o <= fault_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_long_flat: assert property (
    req_i && mode_i == SAT_LONG && !aux_i |=> valid_o && addr_o == $past(ea_i) && !fault_o)
    else $error("64-bit address not flat");
  chk_long_aux: assert property (
    req_i && mode_i == SAT_LONG && aux_i |=> addr_o == $past(ea_i) + {32'h0, $past(base_i)})
    else $error("aux base not added");
  chk_real_wrap: assert property (
    req_i && (mode_i == SAT_REAL || mode_i == SAT_V86) |=> addr_o[63:20] == 44'h0)
    else $error("real address beyond 1MB");
  chk_compat_4g: assert property (
    req_i && mode_i == SAT_COMPAT |=> addr_o[63:32] == 32'h0
      && (fault_o || $past(ea_i[63:32]) == 32'h0))
    else $error("compat address beyond 4G");
endmodule // sat_addr_calc
`default_nettype wire

// [tb/sat_mem_model.sv]
// sat_mem_model: descriptor memory answering the core's fetch requests
// assumes the core holds its request until the acknowledge edge
`timescale 1ns/1ns
`default_nettype none
module sat_mem_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req_i,
  input wire logic [3:0] delay_i,
  input wire logic [31:0] base_i,
  input wire logic [31:0] limit_i,
  input wire logic [7:0] attr_i,
  output logic ack_o,
  output logic [63:0] data_o,
  output logic [7:0] attr_o
);
  logic [3:0] wait_q;
  // outside the answer cycle data toggles, so a late sample is caught
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_o <= 1'b0;
      wait_q <= 4'h0;
      data_o <= 64'h0;
      attr_o <= 8'h00;
    end else if (!ack_o && req_i && wait_q == delay_i) begin
      ack_o <= 1'b1;
      wait_q <= 4'h0;
      data_o <= {limit_i, base_i};
      attr_o <= attr_i;
    end else begin
      ack_o <= 1'b0;
      data_o <= ~data_o;
      attr_o <= ~attr_o;
      wait_q <= (req_i && !ack_o) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule // sat_mem_model
`default_nettype wire

// [tb/sat_top_bench.sv]
// sat_top_bench: register, load, translate and vector sequences on sat_top
// assumes sat_mem_model stands at the descriptor fetch port
`timescale 1ns/1ns
`default_nettype none
module sat_top_bench
  import sat_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [6:0] addr_i = 7'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic seg_load_i = 1'b0;
  logic seg_far_i = 1'b0;
  logic [2:0] seg_idx_i = 3'h0;
  logic [15:0] seg_sel_i = 16'h0;
  logic vec_event_i = 1'b0;
  logic [7:0] vec_num_i = 8'h0;
  logic xlat_req_i = 1'b0;
  logic [2:0] xlat_seg_i = 3'h0;
  logic [63:0] xlat_ea_i = 64'h0;
  logic [3:0] m_delay = 4'h0;
  logic [31:0] m_base = 32'h0;
  logic [31:0] m_limit = 32'h0;
  logic [7:0] m_attr = 8'h0;
  logic [31:0] rdata_o, gate_addr_o, mem_addr_o, last_addr;
  logic [63:0] lin_addr_o, mem_data_i;
  logic [7:0] mem_attr_i;
  logic [2:0] mode_o;
  logic [1:0] cpl_o;
  logic seg_busy_o, gate_valid_o, lin_valid_o, lin_fault_o, mem_req_o, mem_ack_i;
  logic opsize32_o, code64_o;
  logic last_req = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int req_count = 0;
  int c0;

  sat_top sat_top_i (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .seg_load_i(seg_load_i),
    .seg_far_i(seg_far_i), .seg_idx_i(seg_idx_i), .seg_sel_i(seg_sel_i),
    .seg_busy_o(seg_busy_o), .vec_event_i(vec_event_i), .vec_num_i(vec_num_i),
    .gate_valid_o(gate_valid_o), .gate_addr_o(gate_addr_o), .xlat_req_i(xlat_req_i),
    .xlat_seg_i(xlat_seg_i), .xlat_ea_i(xlat_ea_i), .lin_valid_o(lin_valid_o),
    .lin_addr_o(lin_addr_o), .lin_fault_o(lin_fault_o), .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i),
    .mem_attr_i(mem_attr_i), .mode_o(mode_o), .cpl_o(cpl_o), .opsize32_o(opsize32_o),
    .code64_o(code64_o));

  sat_mem_model sat_mem_model_i (.clk_i(clk_i), .reset_i(reset_i), .req_i(mem_req_o),
    .delay_i(m_delay), .base_i(m_base), .limit_i(m_limit), .attr_i(m_attr),
    .ack_o(mem_ack_i), .data_o(mem_data_i), .attr_o(mem_attr_i));

  always #20 clk_i = ~clk_i;

  // fetch starts sampled mid-cycle where registered outputs are settled
  always @(negedge clk_i) begin
    if (mem_req_o === 1'b1 && last_req !== 1'b1) begin
      req_count++;
      last_addr = mem_addr_o;
    end
    last_req = mem_req_o;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("MISMATCH timeout expected done seen hang");
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata", exp, rdata_o);
  endtask

  task automatic set_mode(input logic [1:0] req, input logic [2:0] exp);
    wr(OFS_CTRL, {30'h0, req});
    @(posedge clk_i);
    #1;
    chk("mode", exp, mode_o);
  endtask

  // hold low leaves the fetch running, to test a load refused while busy
  task automatic load(input logic far, input logic [2:0] idx, input logic [15:0] sel,
                      input logic hold);
    int n;
    n = 0;
    @(posedge clk_i);
    seg_load_i <= ~far;
    seg_far_i <= far;
    seg_idx_i <= idx;
    seg_sel_i <= sel;
    @(posedge clk_i);
    seg_load_i <= 1'b0;
    seg_far_i <= 1'b0;
    if (hold) begin
      repeat (2) @(posedge clk_i);
      #1;
      while (seg_busy_o !== 1'b0 && n < 40) begin
        @(posedge clk_i);
        #1;
        n++;
      end
      chk("seg_busy", 1'b0, seg_busy_o);
    end
  endtask

  task automatic xlat(input logic [2:0] s, input logic [63:0] ea, input logic [63:0] exp,
                      input logic flt);
    @(posedge clk_i);
    xlat_req_i <= 1'b1;
    xlat_seg_i <= s;
    xlat_ea_i <= ea;
    @(posedge clk_i);
    xlat_req_i <= 1'b0;
    #1;
    chk("lin_valid", 1'b1, lin_valid_o);
    chk("lin_fault", flt, lin_fault_o);
    if (!flt) chk("lin_addr", exp, lin_addr_o);
  endtask

  task automatic vec(input logic [7:0] v, input logic [31:0] exp);
    @(posedge clk_i);
    vec_event_i <= 1'b1;
    vec_num_i <= v;
    @(posedge clk_i);
    vec_event_i <= 1'b0;
    #1;
    chk("gate_valid", 1'b1, gate_valid_o);
    chk("gate_addr", exp, gate_addr_o);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("mode_rst", 3'h0, mode_o);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_SEL0 + 7'h0c, 32'h0);
    set_mode(REQ_LONG, 3'h0);
    set_mode(REQ_V86, 3'h0);
    for (int i = 0; i < 8; i++) wr(OFS_GTB + 7'(4 * i), 32'h1000 * (i + 2));
    for (int i = 0; i < 8; i++) rd(OFS_GTB + 7'(4 * i), 32'h1000 * (i + 2));
    rd(7'h7c, 32'h0);
    c0 = req_count;
    load(1'b0, SEG_DS, 16'h1234, 1'b1);
    rd(OFS_SEL0 + 7'h0c, 32'h1234);
    @(posedge clk_i);
    #1;
    chk("rdata_idle", 32'h0, rdata_o);
    rd(OFS_BASE0 + 7'h0c, 32'h12340);
    xlat(SEG_DS, 64'hfff0, 64'h22330, 1'b0);
    load(1'b0, SEG_ES, 16'hffff, 1'b1);
    xlat(SEG_ES, 64'hffff, 64'h0ffef, 1'b0);
    load(1'b1, SEG_DS, 16'h0800, 1'b1);
    rd(OFS_BASE0 + 7'h04, 32'h8000);
    rd(OFS_SEL0 + 7'h0c, 32'h1234);
    chk("fetches", c0, req_count);
    vec(8'h05, 32'h6028);
    set_mode(REQ_PROT, 3'h1);
    m_delay = 4'h3;
    m_base = 32'h0050_0000;
    m_limit = 32'h0000_00ff;
    m_attr = 8'h10;
    load(1'b0, SEG_DS, 16'h001c, 1'b1);
    chk("desc_addr", 32'h4018, last_addr);
    rd(OFS_BASE0 + 7'h0c, 32'h0050_0000);
    xlat(SEG_DS, 64'h80, 64'h0050_0080, 1'b0);
    xlat(SEG_DS, 64'h100, 64'h0, 1'b1);
    xlat(SEG_DS, 64'h1_0000_0000, 64'h0, 1'b1);
    m_delay = 4'h6;
    c0 = req_count;
    load(1'b0, SEG_FS, 16'h0028, 1'b0);
    load(1'b0, SEG_FS, 16'h0030, 1'b1);
    chk("fetches", c0 + 1, req_count);
    chk("desc_addr", 32'h2028, last_addr);
    rd(OFS_SEL0 + 7'h10, 32'h0028);
    m_delay = 4'h0;
    m_base = 32'h0;
    m_limit = 32'hffff_ffff;
    load(1'b0, SEG_SS, 16'h0010, 1'b1);
    xlat(SEG_SS, 64'hffff_fff0, 64'hffff_fff0, 1'b0);
    set_mode(REQ_REAL, 3'h0);
    load(1'b0, SEG_DS, 16'h0100, 1'b1);
    xlat(SEG_DS, 64'h0100, 64'h0, 1'b1);
    xlat(SEG_DS, 64'h0010, 64'h1010, 1'b0);
    set_mode(REQ_PROT, 3'h1);
    m_attr = 8'h0a;
    m_base = 32'h0070_0000;
    m_limit = 32'h10;
    load(1'b0, SEG_CS, 16'h0008, 1'b1);
    set_mode(REQ_LONG, 3'h2);
    chk("code64", 1'b1, code64_o);
    chk("cpl", 2'h2, cpl_o);
    chk("opsize32", 1'b0, opsize32_o);
    rd(OFS_STAT, 32'h2);
    xlat(SEG_DS, 64'h1234_5678_9abc_def0, 64'h1234_5678_9abc_def0, 1'b0);
    xlat(SEG_CS, 64'h20, 64'h20, 1'b0);
    wr(OFS_AUX1, 32'h1000);
    xlat(SEG_FS, 64'h10, 64'h1010, 1'b0);
    vec(8'hff, 32'h67f8);
    set_mode(REQ_PROT, 3'h1);
    m_attr = 8'h04;
    load(1'b0, SEG_CS, 16'h0008, 1'b1);
    set_mode(REQ_LONG, 3'h3);
    chk("code64", 1'b0, code64_o);
    chk("opsize32", 1'b1, opsize32_o);
    xlat(SEG_SS, 64'h1_0000_0000, 64'h0, 1'b1);
    xlat(SEG_SS, 64'hffff_0000, 64'hffff_0000, 1'b0);
    m_attr = 8'h0a;
    load(1'b0, SEG_CS, 16'h0008, 1'b1);
    @(posedge clk_i);
    #1;
    chk("mode", 3'h2, mode_o);
    set_mode(REQ_PROT, 3'h1);
    set_mode(REQ_V86, 3'h6);
    c0 = req_count;
    load(1'b0, SEG_SS, 16'h2000, 1'b1);
    rd(OFS_BASE0 + 7'h08, 32'h20000);
    xlat(SEG_SS, 64'hffff, 64'h2ffff, 1'b0);
    load(1'b1, SEG_ES, 16'h0900, 1'b1);
    rd(OFS_BASE0 + 7'h04, 32'h9000);
    chk("fetches", c0, req_count);
    vec(8'h01, 32'h6008);
    @(posedge clk_i);
    #1;
    chk("mode", 3'h1, mode_o);
    wrap_up();
  end
endmodule // sat_top_bench
`default_nettype wire
